// ===== logic/usfl_pkg.sv
// usfl_pkg: register map, field positions, reset values and state codes
// for the control endpoint status block.
// assumes one 100 MHz clock shared by the engine and the register port.
package usfl_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int DEV_ADDR_W = 7;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_STATUS = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_ADDR = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STS = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 3'h4;

	// engine_status_reg fields
	localparam int B_DEFER = 0;
	localparam int B_FIFO = 1;
	localparam int B_OUT = 2;
	localparam int B_IN = 3;
	localparam int B_NORESP = 4;
	localparam int B_LINK = 6;
	localparam int B_NAKMASK = 7;

	// address_wakeup_reg fields
	localparam int B_WAKE = 0;
	localparam int ADDR_LSB = 1;
	localparam int ADDR_MSB = 7;

	// sticky engine flags, index into the flag vector
	localparam int NFLAG = 4;
	localparam int F_FIFO = 0;
	localparam int F_OUT = 1;
	localparam int F_NORESP = 2;
	localparam int F_LINK = 3;

	// interrupt status / enable / clear layout
	localparam int IRQ_W = 6;
	localparam int I_NAK = 0;
	localparam int I_FIFO = 1;
	localparam int I_OUT = 2;
	localparam int I_NORESP = 3;
	localparam int I_LINK = 4;
	localparam int I_ADDR = 5;

	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [DEV_ADDR_W-1:0] RST_DEV_ADDR = 7'h00;

	typedef enum logic {
		ADDR_IDLE = 1'b0,
		ADDR_PEND = 1'b1
	} usfl_addr_state_t;
endpackage

// ===== logic/usfl_flag.sv
// usfl_flag: a vector of sticky flags, set by hardware, cleared by a mask.
// assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module usfl_flag #(
	parameter int W = 4
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	// set after clear so a same-cycle event is never lost
	always_comb begin
		q_next = (q_reg & ~clr) | set;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;
endmodule // usfl_flag

// ===== logic/usfl_addr.sv
// usfl_addr: address_wakeup_reg and the device address the engine answers.
// assumes in_done pulses once per acknowledged control endpoint IN.
`timescale 1ns/1ps
module usfl_addr (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [usfl_pkg::DATA_W-1:0] wr_data,
	input wire logic deferred,
	input wire logic in_done,
	output logic [usfl_pkg::DATA_W-1:0] address_wakeup_reg,
	output logic [usfl_pkg::DEV_ADDR_W-1:0] dev_addr,
	output logic applied
);
	usfl_pkg::usfl_addr_state_t st_reg;
	usfl_pkg::usfl_addr_state_t st_next;
	logic [usfl_pkg::DATA_W-1:0] awr_reg;
	logic [usfl_pkg::DATA_W-1:0] awr_next;
	logic [usfl_pkg::DEV_ADDR_W-1:0] dev_reg;
	logic [usfl_pkg::DEV_ADDR_W-1:0] dev_next;

	always_comb begin
		st_next = st_reg;
		awr_next = awr_reg;
		dev_next = dev_reg;
		applied = 1'b0;
		if (wr_en) begin
			awr_next = wr_data;
			if (!deferred) begin
				// immediate adoption
				dev_next = wr_data[usfl_pkg::ADDR_MSB:usfl_pkg::ADDR_LSB];
				applied = 1'b1;
				st_next = usfl_pkg::ADDR_IDLE;
			end else begin
				st_next = usfl_pkg::ADDR_PEND;
			end
		end else begin
			unique case (st_reg)
				usfl_pkg::ADDR_IDLE: begin
				end
				usfl_pkg::ADDR_PEND: begin
					// wait for the host to take the status-stage data
					if (in_done) begin
						dev_next = awr_reg[usfl_pkg::ADDR_MSB:usfl_pkg::ADDR_LSB];
						applied = 1'b1;
						st_next = usfl_pkg::ADDR_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= usfl_pkg::ADDR_IDLE;
			awr_reg <= usfl_pkg::RST_BYTE;
			dev_reg <= usfl_pkg::RST_DEV_ADDR;
		end else begin
			st_reg <= st_next;
			awr_reg <= awr_next;
			dev_reg <= dev_next;
		end
	end

	assign address_wakeup_reg = awr_reg;
	assign dev_addr = dev_reg;
endmodule // usfl_addr

// ===== logic/usfl_ep0_status.sv
// usfl_ep0_status: control endpoint status register, address update,
// and the interrupt gathering of the serial interface engine.
// assumes all engine event inputs are one-cycle pulses on mclk,
// and the register port master never strobes read and write together.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Summary of operation
// - With the deferred bit set, a new address takes effect only after an acknowledged control IN.
// - With the deferred bit clear, a written address takes effect at once.
// - Any FIFO access error on any endpoint sets a sticky fault flag, bit 1.
// - A control OUT with data sets the received-out flag, bit 2, which firmware clears.
// - A valid SETUP token clears the received-out flag in hardware.
// - Read-only bit 3 shows that the current control token is an IN.
// - A token left unanswered through an error sets bit 4 until firmware clears it.
// - A CRC, PID or bit-stuffing error sets the sticky link error flag, bit 6.
// - Bit 7 set hides NAK handshakes from the interrupt, clear lets each NAK raise it.
// - Status functions other than the FIFO fault flag cover the control endpoint only, the NAK mask all endpoints.
// - The address register holds the address in bits 7..1, wakeup in bit 0, both reset 0.
module usfl_ep0_status (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [usfl_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [usfl_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [usfl_pkg::DATA_W-1:0] reg_rdata,
	input wire logic tok_ep0,
	input wire logic tok_in,
	input wire logic setup_ok,
	input wire logic in_ack,
	input wire logic out_data,
	input wire logic fifo_err,
	input wire logic no_resp,
	input wire logic crc_err,
	input wire logic pid_err,
	input wire logic stuff_err,
	input wire logic nak_sent,
	output logic [usfl_pkg::DEV_ADDR_W-1:0] dev_addr,
	output logic remote_wakeup_enable,
	output logic irq
);
	function automatic logic hit(
		input logic [usfl_pkg::ADDR_W-1:0] a,
		input logic [usfl_pkg::ADDR_W-1:0] off,
		input logic strobe
	);
		hit = strobe && (a == off);
	endfunction

	logic wr_status;
	logic wr_addr;
	logic wr_irq_en;
	logic wr_irq_clr;
	logic defer_reg;
	logic defer_next;
	logic mask_reg;
	logic mask_next;
	logic [usfl_pkg::NFLAG-1:0] flag_set;
	logic [usfl_pkg::NFLAG-1:0] flag_clr;
	logic [usfl_pkg::NFLAG-1:0] flag_q;
	logic [usfl_pkg::IRQ_W-1:0] ev_set;
	logic [usfl_pkg::IRQ_W-1:0] ev_clr;
	logic [usfl_pkg::IRQ_W-1:0] irq_sts;
	logic [usfl_pkg::IRQ_W-1:0] irq_en_reg;
	logic [usfl_pkg::IRQ_W-1:0] irq_en_next;
	logic [usfl_pkg::DATA_W-1:0] address_wakeup_reg;
	logic [usfl_pkg::DATA_W-1:0] status;
	logic [usfl_pkg::DATA_W-1:0] rd_next;
	logic [usfl_pkg::DATA_W-1:0] rd_reg;
	logic addr_applied;
	logic in_done;

	////////////////////////////////////////////////////////////////////
	// register decode

	always_comb begin
		wr_status = hit(reg_addr, usfl_pkg::OFF_STATUS, reg_wr);
		wr_addr = hit(reg_addr, usfl_pkg::OFF_ADDR, reg_wr);
		wr_irq_en = hit(reg_addr, usfl_pkg::OFF_IRQ_EN, reg_wr);
		wr_irq_clr = hit(reg_addr, usfl_pkg::OFF_IRQ_CLR, reg_wr);
	end

	////////////////////////////////////////////////////////////////////
	// control bits: deferred update and NAK mask

	always_comb begin
		defer_next = defer_reg;
		mask_next = mask_reg;
		if (wr_status) begin
			// cleared by firmware after the next SETUP
			defer_next = reg_wdata[usfl_pkg::B_DEFER];
			mask_next = reg_wdata[usfl_pkg::B_NAKMASK];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			defer_reg <= 1'b0;
			mask_reg <= 1'b0;
		end else begin
			defer_reg <= defer_next;
			mask_reg <= mask_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// sticky engine flags

	always_comb begin
		flag_set = '0;
		flag_set[usfl_pkg::F_FIFO] = fifo_err;
		// out, no-answer and link errors count on the control endpoint only
		flag_set[usfl_pkg::F_OUT] = out_data && tok_ep0;
		flag_set[usfl_pkg::F_NORESP] = no_resp && tok_ep0;
		flag_set[usfl_pkg::F_LINK] =
			(crc_err || pid_err || stuff_err) && tok_ep0;
		flag_clr = '0;
		if (wr_status) begin
			// write zero clears, write one leaves the flag alone
			flag_clr[usfl_pkg::F_FIFO] = !reg_wdata[usfl_pkg::B_FIFO];
			flag_clr[usfl_pkg::F_OUT] = !reg_wdata[usfl_pkg::B_OUT];
			flag_clr[usfl_pkg::F_NORESP] = !reg_wdata[usfl_pkg::B_NORESP];
			flag_clr[usfl_pkg::F_LINK] = !reg_wdata[usfl_pkg::B_LINK];
		end
		if (setup_ok && tok_ep0) begin
			flag_clr[usfl_pkg::F_OUT] = 1'b1;
		end
	end

	usfl_flag #(
		.W(usfl_pkg::NFLAG)
	) u_flags (
		.mclk(mclk),
		.arst_n(arst_n),
		.set(flag_set),
		.clr(flag_clr),
		.q(flag_q)
	);

	////////////////////////////////////////////////////////////////////
	// device address

	assign in_done = in_ack && tok_ep0;

	usfl_addr u_addr (
		.mclk(mclk),
		.arst_n(arst_n),
		.wr_en(wr_addr),
		.wr_data(reg_wdata),
		.deferred(defer_reg),
		.in_done(in_done),
		.address_wakeup_reg(address_wakeup_reg),
		.dev_addr(dev_addr),
		.applied(addr_applied)
	);

	assign remote_wakeup_enable = address_wakeup_reg[usfl_pkg::B_WAKE];

	////////////////////////////////////////////////////////////////////
	// interrupt status, enable and clear

	always_comb begin
		ev_set = '0;
		// the mask spans every endpoint, so no tok_ep0 term here
		ev_set[usfl_pkg::I_NAK] = nak_sent && !mask_reg;
		ev_set[usfl_pkg::I_FIFO] = flag_set[usfl_pkg::F_FIFO];
		ev_set[usfl_pkg::I_OUT] = flag_set[usfl_pkg::F_OUT];
		ev_set[usfl_pkg::I_NORESP] = flag_set[usfl_pkg::F_NORESP];
		ev_set[usfl_pkg::I_LINK] = flag_set[usfl_pkg::F_LINK];
		ev_set[usfl_pkg::I_ADDR] = addr_applied;
		ev_clr = wr_irq_clr ? reg_wdata[usfl_pkg::IRQ_W-1:0] : '0;
		irq_en_next = irq_en_reg;
		if (wr_irq_en) begin
			irq_en_next = reg_wdata[usfl_pkg::IRQ_W-1:0];
		end
	end

	usfl_flag #(
		.W(usfl_pkg::IRQ_W)
	) u_irq (
		.mclk(mclk),
		.arst_n(arst_n),
		.set(ev_set),
		.clr(ev_clr),
		.q(irq_sts)
	);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_en_reg <= '0;
		end else begin
			irq_en_reg <= irq_en_next;
		end
	end

	assign irq = |(irq_sts & irq_en_reg);

	////////////////////////////////////////////////////////////////////
	// read path

	always_comb begin
		status = usfl_pkg::RST_BYTE; // bit 5 stays zero
		status[usfl_pkg::B_DEFER] = defer_reg;
		status[usfl_pkg::B_FIFO] = flag_q[usfl_pkg::F_FIFO];
		status[usfl_pkg::B_OUT] = flag_q[usfl_pkg::F_OUT];
		status[usfl_pkg::B_IN] = tok_in && tok_ep0;
		status[usfl_pkg::B_NORESP] = flag_q[usfl_pkg::F_NORESP];
		status[usfl_pkg::B_LINK] = flag_q[usfl_pkg::F_LINK];
		status[usfl_pkg::B_NAKMASK] = mask_reg;
		rd_next = usfl_pkg::RST_BYTE;
		if (reg_rd) begin
			case (reg_addr)
				usfl_pkg::OFF_STATUS: rd_next = status;
				usfl_pkg::OFF_ADDR: rd_next = address_wakeup_reg;
				usfl_pkg::OFF_IRQ_STS: rd_next = {2'h0, irq_sts};
				usfl_pkg::OFF_IRQ_EN: rd_next = {2'h0, irq_en_reg};
				// clear register and holes read zero
				default: rd_next = usfl_pkg::RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_reg <= usfl_pkg::RST_BYTE;
		end else begin
			rd_reg <= rd_next;
		end
	end

	assign reg_rdata = rd_reg;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	set_beats_clear_a: assert property (
		wr_status && !reg_wdata[usfl_pkg::B_LINK]
		&& flag_set[usfl_pkg::F_LINK] |=> flag_q[usfl_pkg::F_LINK])
		else $error("link flag lost on same-cycle clear");

	setup_clears_out_a: assert property (
		setup_ok && tok_ep0 && !flag_set[usfl_pkg::F_OUT]
		|=> !flag_q[usfl_pkg::F_OUT])
		else $error("out flag survived a setup token");

	out_sets_flag_a: assert property (
		out_data && tok_ep0
		|=> flag_q[usfl_pkg::F_OUT])
		else $error("out flag not set");

	imm_address_a: assert property (
		wr_addr && !defer_reg |=>
		dev_addr == address_wakeup_reg[usfl_pkg::ADDR_MSB:usfl_pkg::ADDR_LSB])
		else $error("address not adopted at once");

	deferred_hold_a: assert property (
		wr_addr && defer_reg && !in_done ##1 !in_done && !wr_addr
		|=> $stable(dev_addr))
		else $error("deferred address adopted early");

	deferred_apply_a: assert property (
		wr_addr && defer_reg ##1 (!wr_addr && in_done) |=>
		dev_addr == address_wakeup_reg[usfl_pkg::ADDR_MSB:usfl_pkg::ADDR_LSB])
		else $error("deferred address not adopted after IN");

	nak_masked_a: assert property (
		nak_sent && mask_reg && !irq_sts[usfl_pkg::I_NAK]
		&& !wr_status |=> !irq_sts[usfl_pkg::I_NAK])
		else $error("masked NAK raised an event");

	nak_irq_a: assert property (
		nak_sent && !mask_reg && irq_en_reg[usfl_pkg::I_NAK]
		&& !wr_irq_en |=> irq)
		else $error("unmasked NAK gave no interrupt");

	link_error_a: assert property (
		(crc_err || pid_err || stuff_err) && tok_ep0
		|=> flag_q[usfl_pkg::F_LINK] [*2] or
		(flag_q[usfl_pkg::F_LINK] ##1 $past(wr_status)))
		else $error("link error flag not held");

	fifo_error_a: assert property (
		fifo_err |=> flag_q[usfl_pkg::F_FIFO])
		else $error("fifo fault flag not set");

	no_answer_a: assert property (
		no_resp && tok_ep0 |=> flag_q[usfl_pkg::F_NORESP])
		else $error("no-answer flag not set");

	unused_bit_a: assert property (
		reg_rd && reg_addr == usfl_pkg::OFF_STATUS
		|=> !reg_rdata[5])
		else $error("unused status bit read as one");

	in_token_a: assert property (
		reg_rd && reg_addr == usfl_pkg::OFF_STATUS
		|=> reg_rdata[usfl_pkg::B_IN] == ($past(tok_in) && $past(tok_ep0)))
		else $error("in token bit wrong");

	other_ep_out_a: assert property (
		out_data && !tok_ep0 && !flag_q[usfl_pkg::F_OUT]
		|=> !flag_q[usfl_pkg::F_OUT])
		else $error("out flag set by another endpoint");

	deferred_c: cover property (
		wr_addr && defer_reg ##[1:20] in_done);
	nak_irq_c: cover property (nak_sent && !mask_reg ##1 irq);
	set_clear_c: cover property (
		wr_status && flag_set[usfl_pkg::F_FIFO]
		&& !reg_wdata[usfl_pkg::B_FIFO]);
endmodule // usfl_ep0_status

// ===== testbench/usfl_host_model.sv
// usfl_host_model: stands in for the host and the token decoder in front
// of the status block. assumes the bench changes cmd right after a rising
// mclk edge and holds each code for one cycle only.
`timescale 1ns/1ps
module usfl_host_model (
	input wire logic [3:0] cmd,
	input wire logic ep0,
	input wire logic in_tok,
	output logic tok_ep0,
	output logic tok_in,
	output logic setup_ok,
	output logic in_ack,
	output logic out_data,
	output logic fifo_err,
	output logic no_resp,
	output logic crc_err,
	output logic pid_err,
	output logic stuff_err,
	output logic nak_sent
);
	////////////////////////////////////////////////////////////////////
	// pulses last one cycle because cmd does; levels follow the bench
	always_comb begin
		tok_ep0 = ep0;
		tok_in = in_tok;
		setup_ok = (cmd == 4'h1);
		in_ack = (cmd == 4'h2);
		out_data = (cmd == 4'h3);
		fifo_err = (cmd == 4'h4);
		no_resp = (cmd == 4'h5);
		crc_err = (cmd == 4'h6);
		pid_err = (cmd == 4'h7);
		stuff_err = (cmd == 4'h8);
		nak_sent = (cmd == 4'h9);
	end
endmodule // usfl_host_model

// ===== testbench/usfl_ep0_status_test.sv
// usfl_ep0_status_test: register-port tests of the control endpoint status
// block. assumes one 100 MHz clock and the host model for engine events.
`timescale 1ns/1ps
module usfl_ep0_status_test;
	logic mclk, arst_n, reg_wr, reg_rd, ep0, in_tok, irq, wake;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] cmd;
	logic [6:0] dev_addr;
	logic te, ti, su, ia, od, fe, nr, ce, pe, se, ns;
	int err_count, n_compared;
	logic [3:0] codes [6] = '{4'h4, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8};
	logic [7:0] sbits [6] = '{8'h02, 8'h04, 8'h10, 8'h40, 8'h40, 8'h40};
	logic [7:0] ibits [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h10, 8'h10};

	usfl_host_model i_host (.cmd(cmd), .ep0(ep0), .in_tok(in_tok),
		.tok_ep0(te), .tok_in(ti), .setup_ok(su), .in_ack(ia),
		.out_data(od), .fifo_err(fe), .no_resp(nr), .crc_err(ce),
		.pid_err(pe), .stuff_err(se), .nak_sent(ns));
	usfl_ep0_status i_dut (.mclk(mclk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_ep0(te),
		.tok_in(ti), .setup_ok(su), .in_ack(ia), .out_data(od),
		.fifo_err(fe), .no_resp(nr), .crc_err(ce), .pid_err(pe),
		.stuff_err(se), .nak_sent(ns), .dev_addr(dev_addr),
		.remote_wakeup_enable(wake), .irq(irq));

	////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		// step off the edge so callers see settled outputs
		#1;
	endtask

	// data stands only in the cycle after the strobe, so sample there
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic ev(input logic [3:0] c, input logic e);
		@(posedge mclk);
		cmd <= c;
		ep0 <= e;
		@(posedge mclk);
		cmd <= 4'h0;
		#1;
	endtask

	task automatic clear_all();
		wr(usfl_pkg::OFF_STATUS, 8'h00);
		wr(usfl_pkg::OFF_IRQ_CLR, 8'h3F);
	endtask

	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// watchdog: the tests take a few microseconds
	initial begin
		#50000;
		err_count++;
		print_verdict();
	end

	initial begin
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		cmd = 4'h0;
		ep0 = 1'b0;
		in_tok = 1'b0;
		err_count = 0;
		n_compared = 0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		rd(usfl_pkg::OFF_STATUS, 8'h00);
		rd(usfl_pkg::OFF_ADDR, 8'h00);
		chk({1'b0, dev_addr}, 8'h00);
		chk({7'h00, irq}, 8'h00);
		// ones never set flags, bit 5 stays zero
		wr(usfl_pkg::OFF_STATUS, 8'hFF);
		rd(usfl_pkg::OFF_STATUS, 8'h81);
		wr(usfl_pkg::OFF_IRQ_EN, 8'h3F);
		clear_all();
		for (int i = 0; i < 6; i++) begin
			if (i > 0) begin
				ev(codes[i], 1'b0);
				rd(usfl_pkg::OFF_STATUS, 8'h00);
			end
			ev(codes[i], i > 0);
			rd(usfl_pkg::OFF_STATUS, sbits[i]);
			rd(usfl_pkg::OFF_IRQ_STS, ibits[i]);
			chk({7'h00, irq}, 8'h01);
			clear_all();
			rd(usfl_pkg::OFF_STATUS, 8'h00);
			chk({7'h00, irq}, 8'h00);
		end
		ev(4'h3, 1'b1);
		ev(4'h1, 1'b1);
		rd(usfl_pkg::OFF_STATUS, 8'h00);
		// firmware clear and engine set in one cycle: the set wins
		fork
			wr(usfl_pkg::OFF_STATUS, 8'h00);
			ev(4'h4, 1'b0);
		join
		rd(usfl_pkg::OFF_STATUS, 8'h02);
		clear_all();
		// interrupt enable gates the output but not the status
		wr(usfl_pkg::OFF_IRQ_EN, 8'h00);
		ev(4'h4, 1'b0);
		chk({7'h00, irq}, 8'h00);
		wr(usfl_pkg::OFF_IRQ_EN, 8'h3F);
		chk({7'h00, irq}, 8'h01);
		clear_all();
		in_tok <= 1'b1;
		ep0 <= 1'b1;
		rd(usfl_pkg::OFF_STATUS, 8'h08);
		ep0 <= 1'b0;
		rd(usfl_pkg::OFF_STATUS, 8'h00);
		in_tok <= 1'b0;
		ev(4'h9, 1'b0);
		rd(usfl_pkg::OFF_IRQ_STS, 8'h01);
		chk({7'h00, irq}, 8'h01);
		wr(usfl_pkg::OFF_IRQ_CLR, 8'h3F);
		wr(usfl_pkg::OFF_STATUS, 8'h80);
		ev(4'h9, 1'b1);
		rd(usfl_pkg::OFF_IRQ_STS, 8'h00);
		chk({7'h00, irq}, 8'h00);
		clear_all();
		wr(usfl_pkg::OFF_ADDR, 8'h0B);
		chk({1'b0, dev_addr}, 8'h05);
		chk({7'h00, wake}, 8'h01);
		rd(usfl_pkg::OFF_ADDR, 8'h0B);
		// start the deferred case with no address event pending
		wr(usfl_pkg::OFF_IRQ_CLR, 8'h3F);
		wr(usfl_pkg::OFF_STATUS, 8'h01);
		ev(4'h1, 1'b1);
		wr(usfl_pkg::OFF_ADDR, 8'h14);
		chk({1'b0, dev_addr}, 8'h05);
		ev(4'h2, 1'b0);
		chk({1'b0, dev_addr}, 8'h05);
		rd(usfl_pkg::OFF_IRQ_STS, 8'h00);
		ev(4'h2, 1'b1);
		chk({1'b0, dev_addr}, 8'h0A);
		rd(usfl_pkg::OFF_IRQ_STS, 8'h20);
		ev(4'h1, 1'b1);
		clear_all();
		wr(usfl_pkg::OFF_ADDR, 8'h07);
		chk({1'b0, dev_addr}, 8'h03);
		// reset in mid-run brings address and wakeup back to zero
		@(posedge mclk);
		arst_n <= 1'b0;
		@(posedge mclk);
		arst_n <= 1'b1;
		#1;
		chk({1'b0, dev_addr}, 8'h00);
		chk({7'h00, wake}, 8'h00);
		rd(3'h5, 8'h00);
		rd(usfl_pkg::OFF_IRQ_CLR, 8'h00);
		print_verdict();
	end
endmodule // usfl_ep0_status_test
